// file: hdl/acr_pkg.sv
// Constants, types and field layout for the converter calibration register bank
//==========================================================================
// Overview of operation
// RQ1: Dual mode: swap bit exchanges channel inputs
// RQ2: Single mode: field picks first or second input
// RQ3: Enable high runs calibration, low holds reset
// RQ4: Enable low also resets clock dividers
// RQ5: Software disables calibration before changing settings
// RQ6: Calibration enabled before link, disabled after
// RQ7: Configuration written only while calibration disabled; writes while enabled are accepted and flagged as an ordering event
// RQ8: Config bit 4 enables offset filtering
// RQ9: Background offset needs background calibration enabled
// RQ10: Foreground offset needs foreground calibration selected
// RQ11: Config bit 1 enables background calibration
// RQ12: Values always reset; foreground runs or skipped
// RQ13: Stopped flag follows background pause and resume
// RQ14: Foreground-finished flag sets on foreground completion
// RQ15: Pin select mirrors done, alarm, or low
// RQ16: Trigger source bit picks hardware or software
// RQ17: Software trigger bit stands in for input
// RQ18: Software writes reserved bits with reset values
//==========================================================================
package acr_pkg;

	//==================================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_ROUTING   = 8'h60;
	localparam logic [7:0] IDX_CAL_EN    = 8'h61;
	localparam logic [7:0] IDX_CAL_CFG   = 8'h62;
	localparam logic [7:0] IDX_CAL_STATE = 8'h6A;
	localparam logic [7:0] IDX_PIN_SETUP = 8'h6B;
	localparam logic [7:0] IDX_SOFT_TRIG = 8'h6C;
	localparam logic [7:0] IDX_LINK_CTRL = 8'hF0;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'hF1;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'hF2;

	//==================================================================
	// Reset values
	localparam logic [7:0] RST_ROUTING   = 8'h01;
	localparam logic [7:0] RST_CAL_EN    = 8'h01;
	localparam logic [7:0] RST_CAL_CFG   = 8'h01;
	localparam logic [7:0] RST_PIN_SETUP = 8'h00;
	localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
	localparam logic [7:0] RST_LINK_CTRL = 8'h00;
	localparam logic [7:0] RST_IRQ       = 8'h00;

	//==================================================================
	// Field positions
	localparam int ROUTE_SWAP    = 4;
	localparam int ROUTE_SEL_LSB = 0;
	localparam int CAL_EN_BIT    = 0;
	localparam int CFG_FG        = 0;
	localparam int CFG_BG        = 1;
	localparam int CFG_OS        = 2;
	localparam int CFG_BGOS      = 3;
	localparam int CFG_OSFILT    = 4;
	localparam int ST_FOREGROUND_FINISHED    = 0;
	localparam int ST_STOPPED    = 1;
	localparam int PIN_TRIG_SEL  = 0;
	localparam int PIN_STAT_LSB  = 1;
	localparam int SOFT_BIT      = 0;
	localparam int LINK_EN_BIT   = 0;
	localparam int LINK_FMT_BIT  = 1;
	localparam int EV_FOREGROUND_FINISHED    = 0;
	localparam int EV_STOPPED    = 1;
	localparam int EV_ORDER      = 2;

	//==================================================================
	// Field codes
	localparam logic [1:0] SEL_SECOND = 2'h2;
	localparam logic [1:0] PIN_FG     = 2'h0;
	localparam logic [1:0] PIN_ALARM  = 2'h2;

	//==================================================================
	// Calibration sequencer states
	typedef enum logic [2:0] {
		ST_HELD   = 3'b000,
		ST_CLEAR  = 3'b001,
		ST_FORE   = 3'b010,
		ST_BACK   = 3'b011,
		ST_PAUSED = 3'b100,
		ST_IDLE   = 3'b101
	} acr_cal_state_t;

	//==================================================================
	// Bus and output carriers
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [11:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} acr_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} acr_wb_rsp_t;

	typedef struct packed {
		logic run;
		logic divider_reset;
		logic values_reset;
		logic fg_active;
		logic bg_active;
		logic offset_fg;
		logic offset_bg;
		logic offset_filter;
	} acr_cal_out_t;

	typedef struct packed {
		logic a_from_second;
		logic b_from_second;
		logic single_from_second;
	} acr_route_t;

endpackage

// file: hdl/acr_regs.sv
// Calibration control register bank with sequencer, status pin and interrupt
`timescale 1ns/1ps
`default_nettype none
module acr_regs #(
	parameter int FG_CAL_CYCLES = 1024
) (
	// Clock, reset, enable
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 ce,
	// Wishbone slave
	input  wire acr_pkg::acr_wb_req_t wb_req,
	output var  acr_pkg::acr_wb_rsp_t wb_rsp,
	// Device side inputs
	input  wire logic                 hardware_trigger_input,
	input  wire logic                 alarm,
	// Device side outputs
	output var  acr_pkg::acr_cal_out_t cal_out,
	output var  acr_pkg::acr_route_t  route,
	output var  logic                 serial_link_enable,
	output var  logic                 calibration_status_pin,
	output var  logic                 irq
);
	import acr_pkg::*;

	//==================================================================
	// Declarations
	localparam int CW = $clog2(FG_CAL_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(FG_CAL_CYCLES - 1);

	logic [7:0]     routing_q;      // Input routing
	logic [7:0]     cal_en_q;       // Calibration enable
	logic [7:0]     cfg_q;          // Calibration configuration
	logic [7:0]     pin_q;          // Pin setup and trigger source
	logic [7:0]     soft_q;         // Software trigger
	logic [7:0]     link_q;         // Link enable and format
	logic [7:0]     irq_stat_q;     // Sticky event flags
	logic [7:0]     irq_mask_q;     // Event mask
	logic           foreground_finished_q;      // Foreground finished
	logic           stopped_q;      // Calibration stopped
	logic [CW-1:0]  cnt_q;          // Foreground duration counter
	acr_cal_state_t state_q;        // Sequencer state
	acr_cal_state_t state_d;
	acr_wb_rsp_t    rsp_q;          // Bus answer
	acr_cal_out_t   cal_q;          // Registered calibration controls
	acr_route_t     route_q;        // Registered routing
	logic           pin_out_q;      // Status pin
	logic           irq_q;          // Interrupt line
	logic           access;         // Bus request taken this cycle
	logic           wr;             // Write strobe on low byte lane
	logic [7:0]     idx;            // Register index
	logic [7:0]     wdat;           // Write byte
	logic           trig;           // Selected trigger
	logic           single_mode;    // Single-channel link format
	logic [7:0]     ev;             // Event pulses this cycle
	logic           fg_last;        // Final foreground cycle

	//==================================================================
	// Decode helper: write hits the given index
	function automatic logic hit(input logic w, input logic [7:0] i, input logic [7:0] t);
		hit = w && (i == t);
	endfunction

	assign access      = ce && wb_req.cyc && wb_req.stb && !rsp_q.ack;
	assign wr          = access && wb_req.we && wb_req.sel[0];
	assign idx         = wb_req.adr[9:2];
	assign wdat        = wb_req.dat[7:0];
	assign single_mode = link_q[LINK_FMT_BIT];
	// Hardware input or software bit, never both
	assign trig        = pin_q[PIN_TRIG_SEL] ? hardware_trigger_input : soft_q[SOFT_BIT]; // RQ16 RQ17
	assign fg_last     = (state_q == ST_FORE) && (cnt_q == CNT_LAST);

	//==================================================================
	// Bus answer: ack one cycle after the request, dropped right after
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_q <= '0;
		end else if (ce) begin
			rsp_q.ack <= access;
			if (access && !wb_req.we) begin
				unique case (idx)
					IDX_ROUTING:   rsp_q.dat <= {24'h000000, routing_q};
					IDX_CAL_EN:    rsp_q.dat <= {24'h000000, cal_en_q};
					IDX_CAL_CFG:   rsp_q.dat <= {24'h000000, cfg_q};
					IDX_CAL_STATE: rsp_q.dat <= {30'h00000000, stopped_q, foreground_finished_q};
					IDX_PIN_SETUP: rsp_q.dat <= {24'h000000, pin_q};
					IDX_SOFT_TRIG: rsp_q.dat <= {24'h000000, soft_q};
					IDX_LINK_CTRL: rsp_q.dat <= {24'h000000, link_q};
					IDX_IRQ_STAT:  rsp_q.dat <= {24'h000000, irq_stat_q};
					IDX_IRQ_MASK:  rsp_q.dat <= {24'h000000, irq_mask_q};
					// Unmapped reads answer zero
					default:       rsp_q.dat <= 32'h00000000;
				endcase
			end
		end
	end

	//==================================================================
	// Writable registers; reserved bits are stored as written
	always_ff @(posedge clk) begin
		if (reset) begin
			routing_q  <= RST_ROUTING;
			cal_en_q   <= RST_CAL_EN;
			cfg_q      <= RST_CAL_CFG;
			pin_q      <= RST_PIN_SETUP;
			soft_q     <= RST_SOFT_TRIG;
			link_q     <= RST_LINK_CTRL;
			irq_mask_q <= RST_IRQ;
		end else if (ce) begin
			if (hit(wr, idx, IDX_ROUTING))   routing_q  <= wdat;
			if (hit(wr, idx, IDX_CAL_EN))    cal_en_q   <= wdat;
			// Accepted even while enabled; the misuse is flagged instead
			if (hit(wr, idx, IDX_CAL_CFG))   cfg_q      <= wdat;
			if (hit(wr, idx, IDX_PIN_SETUP)) pin_q      <= wdat;
			if (hit(wr, idx, IDX_SOFT_TRIG)) soft_q     <= wdat;
			if (hit(wr, idx, IDX_LINK_CTRL)) link_q     <= wdat;
			if (hit(wr, idx, IDX_IRQ_MASK))  irq_mask_q <= wdat;
		end
	end

	//==================================================================
	// Event pulses feeding the sticky status
	always_comb begin
		ev = 8'h00;
		ev[EV_FOREGROUND_FINISHED] = fg_last && ce;
		ev[EV_STOPPED] = ce && !stopped_q && (state_d == ST_PAUSED || state_d == ST_IDLE);
		// Ordering misuse: link on without calibration, calibration off under link,
		// or configuration rewritten while calibration runs
		ev[EV_ORDER] = (hit(wr, idx, IDX_LINK_CTRL) && wdat[LINK_EN_BIT]
				&& !cal_en_q[CAL_EN_BIT])                                  // RQ6
			|| (hit(wr, idx, IDX_CAL_EN) && !wdat[CAL_EN_BIT]
				&& link_q[LINK_EN_BIT])                                    // RQ6
			|| (hit(wr, idx, IDX_CAL_CFG) && cal_en_q[CAL_EN_BIT]);    // RQ5 RQ7
	end

	//==================================================================
	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_stat_q <= RST_IRQ;
		end else if (ce) begin
			irq_stat_q <= (irq_stat_q & ~(hit(wr, idx, IDX_IRQ_STAT) ? wdat : 8'h00)) | ev;
		end
	end

	// Level interrupt from the stored flags
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	//==================================================================
	// Sequencer next state
	always_comb begin
		state_d = state_q;
		if (!cal_en_q[CAL_EN_BIT]) begin
			// Held in reset while disabled
			state_d = ST_HELD; // RQ3
		end else begin
			unique case (state_q)
				ST_HELD:   state_d = ST_CLEAR;
				// Values cleared either way, then foreground or skip
				ST_CLEAR:  state_d = cfg_q[CFG_FG] ? ST_FORE
					: (cfg_q[CFG_BG] ? ST_BACK : ST_IDLE); // RQ12 RQ11
				ST_FORE:   if (fg_last) state_d = cfg_q[CFG_BG] ? ST_BACK : ST_IDLE;
				// Trigger low stops background at its phase
				ST_BACK:   if (!trig) state_d = ST_PAUSED; // RQ13
				ST_PAUSED: if (trig) state_d = ST_BACK;    // RQ13
				ST_IDLE:   state_d = ST_IDLE;
				default:   state_d = ST_HELD;
			endcase
		end
	end

	// Sequencer state and foreground counter
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= ST_HELD;
			cnt_q   <= '0;
		end else if (ce) begin
			state_q <= state_d;
			cnt_q   <= (state_q == ST_FORE) ? cnt_q + CW'(1) : '0;
		end
	end

	//==================================================================
	// Status flags; undefined after reset, cleared here for determinism
	always_ff @(posedge clk) begin
		if (reset) begin
			foreground_finished_q <= 1'b0;
			stopped_q <= 1'b0;
		end else if (ce) begin
			if (state_d == ST_HELD || state_d == ST_CLEAR) begin
				foreground_finished_q <= 1'b0;
				stopped_q <= 1'b0;
			end else begin
				if (fg_last) foreground_finished_q <= 1'b1; // RQ14
				// Pause, or idle after foreground ends or is skipped with background off
				stopped_q <= (state_d == ST_PAUSED) || (state_d == ST_IDLE); // RQ13
			end
		end
	end

	//==================================================================
	// Calibration controls to the converter core
	always_ff @(posedge clk) begin
		if (reset) begin
			cal_q <= '0;
			cal_q.divider_reset <= 1'b0;
		end else if (ce) begin
			cal_q.run           <= cal_en_q[CAL_EN_BIT];                   // RQ3
			cal_q.divider_reset <= !cal_en_q[CAL_EN_BIT];                  // RQ4
			cal_q.values_reset  <= (state_q == ST_HELD) || (state_q == ST_CLEAR); // RQ12
			cal_q.fg_active     <= (state_q == ST_FORE);
			cal_q.bg_active     <= (state_q == ST_BACK) && cfg_q[CFG_BG];   // RQ11
			// Offset modes only take effect alongside their parent mode
			cal_q.offset_fg     <= cfg_q[CFG_OS] && cfg_q[CFG_FG]
				&& cal_en_q[CAL_EN_BIT];                                   // RQ10
			cal_q.offset_bg     <= cfg_q[CFG_BGOS] && cfg_q[CFG_BG]
				&& cal_en_q[CAL_EN_BIT];                                   // RQ9
			cal_q.offset_filter <= cfg_q[CFG_OSFILT];                      // RQ8
		end
	end

	//==================================================================
	// Input routing; each field ignored in the other link format
	always_ff @(posedge clk) begin
		if (reset) begin
			route_q <= '0;
		end else if (ce) begin
			route_q.a_from_second <= !single_mode && routing_q[ROUTE_SWAP];  // RQ1
			route_q.b_from_second <= !single_mode && !routing_q[ROUTE_SWAP]; // RQ1
			// Reserved codes fall back to the first input
			route_q.single_from_second <= single_mode
				&& (routing_q[ROUTE_SEL_LSB +: 2] == SEL_SECOND);         // RQ2
		end
	end

	//==================================================================
	// Status pin source select
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_out_q <= 1'b0;
		end else if (ce) begin
			unique case (pin_q[PIN_STAT_LSB +: 2])
				PIN_FG:    pin_out_q <= foreground_finished_q; // RQ15
				PIN_ALARM: pin_out_q <= alarm;     // RQ15
				// Reserved code and code 3 hold the pin low
				default:   pin_out_q <= 1'b0;      // RQ15
			endcase
		end
	end

	//==================================================================
	// Outputs straight from flops
	assign wb_rsp                 = rsp_q;
	assign cal_out                = cal_q;
	assign route                  = route_q;
	assign calibration_status_pin = pin_out_q;
	assign irq                    = irq_q;
	assign serial_link_enable     = link_q[LINK_EN_BIT];

	//==================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_route_dual_swap: assert property (ce && !single_mode |=> // RQ1
		route_q.a_from_second == $past(routing_q[ROUTE_SWAP])
		&& route_q.b_from_second != route_q.a_from_second)
		else $error("dual routing does not follow swap bit");

	a_single_pick: assert property (ce |=> // RQ2
		route_q.single_from_second == ($past(single_mode)
		&& $past(routing_q[1:0]) == 2'h2))
		else $error("single input selection wrong");

	a_held_reset: assert property (ce && !cal_en_q[0] |=> state_q == ST_HELD // RQ3
		##1 !ce || cal_q.values_reset)
		else $error("calibration not held in reset");

	a_divider_reset: assert property (ce |=> cal_q.divider_reset == !$past(cal_en_q[0])) // RQ4
		else $error("divider reset does not track enable");

	a_filter_bit: assert property (ce |=> cal_q.offset_filter == $past(cfg_q[4])) // RQ8
		else $error("offset filter mismatch");

	a_bg_offset_gate: assert property (ce && !cfg_q[1] |=> !cal_q.offset_bg) // RQ9
		else $error("background offset without background");

	a_fg_offset_gate: assert property (ce && !cfg_q[0] |=> !cal_q.offset_fg) // RQ10
		else $error("foreground offset without foreground");

	a_fg_skip: assert property (ce && state_q == ST_CLEAR && cal_en_q[0] && !cfg_q[0] // RQ12
		|=> state_q != ST_FORE && !foreground_finished_q)
		else $error("foreground ran when skipped");

	a_foreground_finished_sets: assert property (ce && fg_last && cal_en_q[0] |=> foreground_finished_q) // RQ14
		else $error("foreground finished flag not set");

	a_pause_stops: assert property (ce && state_q == ST_BACK && cal_en_q[0] && !trig // RQ13
		|=> stopped_q && state_q == ST_PAUSED)
		else $error("background pause not flagged");

	a_pin_low: assert property (ce && pin_q[2:1] == 2'h3 |=> !calibration_status_pin) // RQ15
		else $error("status pin not held low");

	a_trig_source: assert property (ce && state_q == ST_BACK && cal_en_q[0] // RQ16
		&& pin_q[0] && hardware_trigger_input |=> state_q == ST_BACK)
		else $error("hardware trigger ignored");

	a_bus_ack: assert property (access |=> wb_rsp.ack ##1 (!wb_rsp.ack || $past(!ce)))
		else $error("bus ack not single cycle");

	c_foreground_finished:   cover property (ce && fg_last);
	c_bg_pause:  cover property (state_q == ST_BACK ##1 state_q == ST_PAUSED);
	c_bg_resume: cover property (state_q == ST_PAUSED ##1 state_q == ST_BACK);
	c_irq:       cover property (irq);

endmodule
`default_nettype wire

// file: sim/tb_adc_calibration_control_regs.sv
// Self-checking bench for the calibration control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_adc_calibration_control_regs;
	import acr_pkg::*;

	//==================================================================
	// Bench signals
	logic         clk;          // 40 MHz clock
	logic         reset;        // Synchronous, active high
	logic         ce;           // Clock enable, high except during the freeze check
	acr_wb_req_t  wb_req;       // Bus request
	acr_wb_rsp_t  wb_rsp;       // Bus answer
	logic         hw_trig;      // Hardware trigger level
	logic         alarm;        // Alarm level
	acr_cal_out_t cal_out;      // Calibration controls
	acr_route_t   route;        // Input routing
	logic         link_en;      // Serial link enable
	logic         stat_pin;     // Status pin
	logic         irq;          // Interrupt level
	logic [7:0]   rd;           // Last read data
	int           mismatches;   // Failed compares
	int           comparisons;  // All compares
	int           cycles;       // Cycle count for the hang guard

	// Table row: write or read, index, data or expected data
	typedef struct packed {
		logic       we;
		logic [7:0] idx;
		logic [7:0] dat;
	} acr_row_t;

	// Reset values, read-back and an unmapped place
	acr_row_t rows [0:11] = '{
		'{1'h0, IDX_ROUTING, 8'h01}, '{1'h0, IDX_CAL_EN, 8'h01},
		'{1'h0, IDX_CAL_CFG, 8'h01}, '{1'h0, IDX_PIN_SETUP, 8'h00},
		'{1'h0, IDX_SOFT_TRIG, 8'h01}, '{1'h0, IDX_LINK_CTRL, 8'h00},
		'{1'h0, IDX_IRQ_MASK, 8'h00}, '{1'h1, 8'h70, 8'hFF},
		'{1'h0, 8'h70, 8'h00}, '{1'h1, IDX_PIN_SETUP, 8'h06},
		'{1'h0, IDX_PIN_SETUP, 8'h06}, '{1'h1, IDX_PIN_SETUP, 8'h00}
	};

	//==================================================================
	// Design under test, short foreground run to keep the bench quick
	acr_regs #(.FG_CAL_CYCLES(8)) dut (
		.clk                    (clk),
		.reset                  (reset),
		.ce                     (ce),
		.wb_req                 (wb_req),
		.wb_rsp                 (wb_rsp),
		.hardware_trigger_input (hw_trig),
		.alarm                  (alarm),
		.cal_out                (cal_out),
		.route                  (route),
		.serial_link_enable     (link_en),
		.calibration_status_pin (stat_pin),
		.irq                    (irq)
	);

	//==================================================================
	// Clock
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	//==================================================================
	// Tasks
	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// One classic cycle; held until ack is seen, only the hang guard ends a wait
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		wb_req <= '{1'h1, 1'h1, we, {2'h0, idx, 2'h0}, 4'hF, {24'h0, d}};
		do begin
			@(posedge clk);
		end while (wb_rsp.ack !== 1'h1);
		rd = wb_rsp.dat[7:0];
		wb_req <= '0;
	endtask

	// Reread until the expected value shows or the tries run out
	task automatic poll(input logic [7:0] idx, input logic [7:0] e);
		int n;
		n = 0;
		do begin
			wb(1'h0, idx, 8'h00);
			n++;
		end while (rd !== e && n < 40);
	endtask

	// Let registered outputs settle
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Single place where the run ends
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	//==================================================================
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	//==================================================================
	// Main sequence
	initial begin
		wb_req = '0;
		reset = 1'h1;
		ce = 1'h1;
		hw_trig = 1'h0;
		alarm = 1'h0;
		cycles = 0;
		mismatches = 0;
		comparisons = 0;
		repeat (10) @(posedge clk);
		reset <= 1'h0;
		// Table cases
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].idx, rows[i].dat);
			if (!rows[i].we)
				check(rd, rows[i].dat);
		end
		// Dual mode swap and no swap
		wb(1'h1, IDX_ROUTING, 8'h10);
		tick(3);
		check({5'h0, route}, 8'h04);
		wb(1'h1, IDX_ROUTING, 8'h00);
		tick(3);
		check({5'h0, route}, 8'h02);
		// Single mode: swap bit ignored, field picks input
		wb(1'h1, IDX_LINK_CTRL, 8'h02);
		wb(1'h1, IDX_ROUTING, 8'h12);
		tick(3);
		check({5'h0, route}, 8'h01);
		wb(1'h1, IDX_ROUTING, 8'h01);
		tick(3);
		check({5'h0, route}, 8'h00);
		wb(1'h1, IDX_LINK_CTRL, 8'h00);
		// Hold calibration, then reprogram the configuration
		wb(1'h1, IDX_CAL_EN, 8'h00);
		tick(3);
		check({5'h0, cal_out.run, cal_out.divider_reset, cal_out.values_reset}, 8'h03);
		// Config only while disabled, reserved bits left zero
		wb(1'h1, IDX_CAL_CFG, 8'h1F);
		wb(1'h1, IDX_CAL_EN, 8'h01);
		poll(IDX_CAL_STATE, 8'h01);
		check(rd, 8'h01);
		check({4'h0, cal_out.offset_fg, cal_out.bg_active, cal_out.offset_bg,
			cal_out.offset_filter}, 8'h0F);
		// Software trigger low pauses background work
		wb(1'h1, IDX_SOFT_TRIG, 8'h00);
		poll(IDX_CAL_STATE, 8'h03);
		check(rd, 8'h03);
		// Events latched, masked, unmasked, cleared
		wb(1'h0, IDX_IRQ_STAT, 8'h00);
		check(rd, 8'h03);
		check({7'h0, irq}, 8'h00);
		wb(1'h1, IDX_IRQ_MASK, 8'h01);
		tick(3);
		check({7'h0, irq}, 8'h01);
		wb(1'h1, IDX_IRQ_STAT, 8'h01);
		tick(3);
		check({7'h0, irq}, 8'h00);
		// Hardware source: input resumes, soft bit ignored
		wb(1'h1, IDX_PIN_SETUP, 8'h01);
		hw_trig <= 1'h1;
		poll(IDX_CAL_STATE, 8'h01);
		check(rd, 8'h01);
		wb(1'h1, IDX_SOFT_TRIG, 8'h01);
		hw_trig <= 1'h0;
		poll(IDX_CAL_STATE, 8'h03);
		check(rd, 8'h03);
		// Status pin sources
		wb(1'h1, IDX_PIN_SETUP, 8'h00);
		tick(3);
		check({7'h0, stat_pin}, 8'h01);
		wb(1'h1, IDX_PIN_SETUP, 8'h04);
		alarm <= 1'h1;
		tick(3);
		check({7'h0, stat_pin}, 8'h01);
		alarm <= 1'h0;
		tick(3);
		check({7'h0, stat_pin}, 8'h00);
		wb(1'h1, IDX_PIN_SETUP, 8'h06);
		tick(3);
		check({7'h0, stat_pin}, 8'h00);
		// Foreground skipped, no background: stopped alone
		wb(1'h1, IDX_CAL_EN, 8'h00);
		wb(1'h1, IDX_CAL_CFG, 8'h00);
		wb(1'h1, IDX_CAL_EN, 8'h01);
		poll(IDX_CAL_STATE, 8'h02);
		check(rd, 8'h02);
		// Link enabled, then calibration cleared under it
		wb(1'h1, IDX_LINK_CTRL, 8'h01);
		tick(3);
		check({7'h0, link_en}, 8'h01);
		wb(1'h1, IDX_CAL_EN, 8'h00);
		wb(1'h0, IDX_IRQ_STAT, 8'h00);
		check({7'h0, rd[2]}, 8'h01);
		// Clock enable low freezes state even under a bus request
		ce <= 1'h0;
		wb_req <= '{1'h1, 1'h1, 1'h1, {2'h0, IDX_CAL_EN, 2'h0}, 4'hF, 32'h00000001};
		tick(3);
		check({6'h0, cal_out.divider_reset, wb_rsp.ack}, 8'h02);
		wb_req <= '0;
		ce <= 1'h1;
		tick(2);
		// Mid-run reset brings registers and outputs back
		reset <= 1'h1;
		tick(2);
		reset <= 1'h0;
		wb(1'h0, IDX_CAL_EN, 8'h00);
		check(rd, 8'h01);
		check({6'h0, link_en, irq}, 8'h00);
		wb(1'h0, IDX_IRQ_STAT, 8'h00);
		check(rd, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
